// File: src/ptc_top.v
// Protection supervisor: master enable, blockings, trip gating,
// collective alarms/trips, breaker trip and fault counter reset.
// Assumes elements on I_CLOCK; digital inputs and the reverse
// interlock pin are asynchronous and get synchronised here.
//
// Behaviour
// - Master enable gates all protection
// - Each stage has own permanent enable
// - Stage trip-block suppresses its breaker command
// - Global block needs permit and asserted source
// - Two global block sources, second optional
// - Stage block needs permit and live source
// - Stage trip block needs permit and source
// - Block sources selectable from internal signal list
// - Global trip block by permitted assigned source
// - Global permanent trip block suppresses the breaker trip
// - Report active when enabled and unblocked
// - Phase alarm ORs running stages' element phase alarms
// - Phase trip ORs authorised element phase trips
// - Overall alarm and trip OR everything
// - Only breaker-assigned trips reach the breaker
// - Current stages also blocked by reverse interlock
// - Reset command clears fault and grid counters
// - Ground collective alarm and trip provided
// - Reset: master enabled, global permit off
//
// Design decisions made here: the register addresses and the APB slave port.
`default_nettype none
`include "ptc_map.vh"

module ptc_top (
    // Clock and reset
    input  wire        I_CLOCK,
    input  wire        I_SRST,
    // APB slave
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [7:0]  I_PADDR,
    input  wire [31:0] I_PWDATA,
    output wire [31:0] O_PRDATA,
    output wire        O_PREADY,
    output wire        O_PSLVERR,
    // Asynchronous pins
    input  wire [7:0]  I_DIN,
    input  wire        I_REV_ILOCK,
    // Element decisions, 4 bits per stage: L1, L2, L3, ground
    input  wire [15:0] I_STG_ALARM,
    input  wire [15:0] I_STG_TRIP,
    // Stage run permissions
    output wire [3:0]  O_STG_RUN,
    // Status
    output wire        O_PROT_ACTIVE,
    output wire        O_EXT_BLOCK,
    output wire        O_TRIP_BLOCKED,
    // Collective alarms
    output wire        O_PHASE1_GENERAL_ALARM,
    output wire        O_PHASE2_GENERAL_ALARM,
    output wire        O_PHASE3_GENERAL_ALARM,
    output wire        O_GROUND_GENERAL_ALARM,
    output wire        O_GENERAL_ALARM,
    // Collective trips
    output wire        O_PHASE1_GENERAL_TRIP,
    output wire        O_PHASE2_GENERAL_TRIP,
    output wire        O_PHASE3_GENERAL_TRIP,
    output wire        O_GROUND_GENERAL_TRIP,
    output wire        O_GENERAL_TRIP,
    // Toward the breaker manager
    output wire        O_BREAKER_TRIP,
    output wire        O_CNT_RESET
);
    integer k;  // Collective OR loop
    integer m;  // Per-stage flag loop, own process
    integer j;  // Settings reset loop, own process

    // Settings
    reg  [31:0] ctrl_reg;
    reg  [31:0] sel_reg;
    reg  [31:0] stg_cfg_reg [0:3];

    // APB state
    reg         pready_reg;
    reg         pslverr_reg;
    reg  [31:0] prdata_reg;
    reg  [31:0] prdata_next;
    reg         hit;

    // Synchronisers
    reg  [7:0]  din_s1_reg;
    reg  [7:0]  din_s2_reg;
    reg         rev_s1_reg;
    reg         rev_s2_reg;

    // Registered results
    reg  [3:0]  run_reg;
    reg         active_reg;
    reg         ext_blk_reg;
    reg         trip_blk_reg;
    reg  [3:0]  alarm_reg;
    reg  [3:0]  trip_reg;
    reg         gen_alarm_reg;
    reg         gen_trip_reg;
    reg         brk_trip_reg;
    reg  [3:0]  stg_alarm_reg;
    reg  [3:0]  stg_trip_reg;

    // Counters
    reg  [15:0] fault_no_reg;
    reg  [15:0] grid_no_reg;
    reg         cnt_clr_reg;

    // Combinational results
    reg  [3:0]  alarm_next;
    reg  [3:0]  trip_next;
    reg         cmd_any;
    wire [31:0] src_list;
    wire        ext_blk;
    wire        master_run;
    wire        trip_blk;
    wire [3:0]  run_w;
    wire [15:0] alarm_w;
    wire [15:0] trip_w;
    wire [15:0] cmd_w;
    wire        acc;
    wire        wr_fire;
    wire [4:0]  sel_a;
    wire [4:0]  sel_b;
    wire [4:0]  sel_t;

    // Pin inputs pass two flops; only stage two is read
    always @(posedge I_CLOCK) begin
        if (I_SRST) begin
            din_s1_reg <= 8'h00;
            din_s2_reg <= 8'h00;
            rev_s1_reg <= 1'b0;
            rev_s2_reg <= 1'b0;
        end else begin
            din_s1_reg <= I_DIN;
            din_s2_reg <= din_s1_reg;
            rev_s1_reg <= I_REV_ILOCK;
            rev_s2_reg <= rev_s1_reg;
        end
    end

    // Signal list: 0 never true, 1-8 inputs, 9-12 stage alarms,
    // 13-16 stage trips, 17-18 general alarm/trip, rest idle.
    // Registered copies only, so no combinational loop forms.
    assign src_list = {13'h0000, gen_trip_reg, gen_alarm_reg,
                       stg_trip_reg, stg_alarm_reg, din_s2_reg, 1'b0};

    assign sel_a = sel_reg[`PTC_SEL_A +: `PTC_SRC_W];
    assign sel_b = sel_reg[`PTC_SEL_B +: `PTC_SRC_W];
    assign sel_t = sel_reg[`PTC_SEL_T +: `PTC_SRC_W];

    // Global block; source B left at 0 means unused
    assign ext_blk = ctrl_reg[`PTC_CTL_XBP]
                   & (src_list[sel_a] | src_list[sel_b]);
    // Master run: enabled and not blocked
    assign master_run = ctrl_reg[`PTC_CTL_EN] & ~ext_blk;

    // Global trip block, permanent or by permitted source
    assign trip_blk = ctrl_reg[`PTC_CTL_GTB]
                    | (ctrl_reg[`PTC_CTL_TXP] & src_list[sel_t]);

    // One gating slice per stage
    genvar g;
    generate
        for (g = 0; g < `PTC_NSTG; g = g + 1) begin : gen_stg
            ptc_stage u_stage (
                .i_master_run (master_run),
                .i_cfg        (stg_cfg_reg[g]),
                .i_blk_sig    (src_list[stg_cfg_reg[g][`PTC_STG_SRC +: `PTC_SRC_W]]),
                .i_trip_sig   (src_list[stg_cfg_reg[g][`PTC_STG_TSRC +: `PTC_SRC_W]]),
                .i_rev_sig    (rev_s2_reg),
                .i_alarm      (I_STG_ALARM[4*g +: 4]),
                .i_trip       (I_STG_TRIP[4*g +: 4]),
                .o_run        (run_w[g]),
                .o_alarm      (alarm_w[4*g +: 4]),
                .o_trip       (trip_w[4*g +: 4]),
                .o_cmd        (cmd_w[4*g +: 4])
            );
        end
    endgenerate

    // Collective ORs per phase and ground across stages
    always @* begin
        alarm_next = 4'h0;
        trip_next  = 4'h0;
        cmd_any    = 1'b0;
        for (k = 0; k < `PTC_NSTG; k = k + 1) begin
            alarm_next = alarm_next | alarm_w[4*k +: 4];
            trip_next  = trip_next | trip_w[4*k +: 4];
            cmd_any    = cmd_any | (|cmd_w[4*k +: 4]);
        end
    end

    // Results land on the edge after inputs change
    always @(posedge I_CLOCK) begin
        if (I_SRST) begin
            run_reg       <= 4'h0;
            active_reg    <= 1'b0;
            ext_blk_reg   <= 1'b0;
            trip_blk_reg  <= 1'b0;
            alarm_reg     <= 4'h0;
            trip_reg      <= 4'h0;
            gen_alarm_reg <= 1'b0;
            gen_trip_reg  <= 1'b0;
            brk_trip_reg  <= 1'b0;
            stg_alarm_reg <= 4'h0;
            stg_trip_reg  <= 4'h0;
        end else begin
            run_reg       <= run_w;
            active_reg    <= master_run;
            ext_blk_reg   <= ext_blk;
            trip_blk_reg  <= trip_blk;
            alarm_reg     <= alarm_next;
            trip_reg      <= trip_next;
            gen_alarm_reg <= |alarm_next;
            gen_trip_reg  <= |trip_next;
            brk_trip_reg  <= cmd_any & ~trip_blk;
            for (m = 0; m < `PTC_NSTG; m = m + 1) begin
                stg_alarm_reg[m] <= |alarm_w[4*m +: 4];
                stg_trip_reg[m]  <= |trip_w[4*m +: 4];
            end
        end
    end

    // APB: one wait state, write lands on the completing edge
    assign acc     = I_PSEL & I_PENABLE;
    assign wr_fire = acc & pready_reg & I_PWRITE;

    // Address decode and read mux
    always @* begin
        hit         = 1'b1;
        prdata_next = 32'h00000000;
        case (I_PADDR)
            `PTC_OFF_CTRL: prdata_next = ctrl_reg;
            `PTC_OFF_SEL:  prdata_next = sel_reg;
            `PTC_OFF_STAT: prdata_next = {20'h00000, gen_trip_reg, gen_alarm_reg,
                                          trip_blk_reg, ext_blk_reg, active_reg,
                                          3'h0, run_reg};
            `PTC_OFF_CMD:  prdata_next = 32'h00000000;
            `PTC_OFF_CNT:  prdata_next = {grid_no_reg, fault_no_reg};
            default: begin
                if (I_PADDR >= `PTC_OFF_STG0 && I_PADDR <= `PTC_OFF_STG3
                    && I_PADDR[1:0] == 2'b00) begin
                    prdata_next = stg_cfg_reg[I_PADDR[3:2]];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    // Bus handshake and registered read data
    always @(posedge I_CLOCK) begin
        if (I_SRST) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else begin
            pready_reg  <= acc & ~pready_reg;
            pslverr_reg <= acc & ~pready_reg & ~hit;
            if (acc & ~pready_reg & ~I_PWRITE) begin
                prdata_reg <= prdata_next;
            end
        end
    end

    // Settings registers; unmapped or read-only writes are dropped
    always @(posedge I_CLOCK) begin
        if (I_SRST) begin
            ctrl_reg <= `PTC_CTRL_RST;
            sel_reg  <= `PTC_SEL_RST;
            for (j = 0; j < `PTC_NSTG; j = j + 1) begin
                stg_cfg_reg[j] <= `PTC_STG_RST;
            end
        end else if (wr_fire) begin
            if (I_PADDR == `PTC_OFF_CTRL) begin
                ctrl_reg <= I_PWDATA & 32'h0000000F;
            end
            if (I_PADDR == `PTC_OFF_SEL) begin
                sel_reg <= I_PWDATA & 32'h001F1F1F;
            end
            if (I_PADDR >= `PTC_OFF_STG0 && I_PADDR <= `PTC_OFF_STG3
                && I_PADDR[1:0] == 2'b00) begin
                stg_cfg_reg[I_PADDR[3:2]] <= I_PWDATA & 32'h001F1F3F;
            end
        end
    end

    // Counter reset command, inactive unless written
    always @(posedge I_CLOCK) begin
        if (I_SRST) begin
            cnt_clr_reg <= 1'b0;
        end else begin
            cnt_clr_reg <= wr_fire && I_PADDR == `PTC_OFF_CMD
                           && I_PWDATA[`PTC_CMD_CLR];
        end
    end

    // Fault number counts trip onsets, grid faults alarm onsets.
    // A new onset in the clear cycle is kept, counted as one.
    always @(posedge I_CLOCK) begin
        if (I_SRST) begin
            fault_no_reg <= 16'h0000;
            grid_no_reg  <= 16'h0000;
        end else if (cnt_clr_reg) begin
            fault_no_reg <= {15'h0000, (|trip_next) & ~gen_trip_reg};
            grid_no_reg  <= {15'h0000, (|alarm_next) & ~gen_alarm_reg};
        end else begin
            if ((|trip_next) & ~gen_trip_reg) begin
                fault_no_reg <= fault_no_reg + 16'h0001;
            end
            if ((|alarm_next) & ~gen_alarm_reg) begin
                grid_no_reg <= grid_no_reg + 16'h0001;
            end
        end
    end

    // Outputs straight from flops
    assign O_PRDATA               = prdata_reg;
    assign O_PREADY               = pready_reg;
    assign O_PSLVERR              = pslverr_reg;
    assign O_STG_RUN              = run_reg;
    assign O_PROT_ACTIVE          = active_reg;
    assign O_EXT_BLOCK            = ext_blk_reg;
    assign O_TRIP_BLOCKED         = trip_blk_reg;
    assign O_PHASE1_GENERAL_ALARM = alarm_reg[0];
    assign O_PHASE2_GENERAL_ALARM = alarm_reg[1];
    assign O_PHASE3_GENERAL_ALARM = alarm_reg[2];
    assign O_GROUND_GENERAL_ALARM = alarm_reg[3];
    assign O_GENERAL_ALARM        = gen_alarm_reg;
    assign O_PHASE1_GENERAL_TRIP  = trip_reg[0];
    assign O_PHASE2_GENERAL_TRIP  = trip_reg[1];
    assign O_PHASE3_GENERAL_TRIP  = trip_reg[2];
    assign O_GROUND_GENERAL_TRIP  = trip_reg[3];
    assign O_GENERAL_TRIP         = gen_trip_reg;
    assign O_BREAKER_TRIP         = brk_trip_reg;
    assign O_CNT_RESET            = cnt_clr_reg;

endmodule // ptc_top

`default_nettype wire

// File: src/ptc_map.vh
// Offsets, field positions, reset values and sizes of the protection
// supervisor. Assumes a 32-bit APB with byte addresses in I_PADDR[7:0].
`ifndef PTC_MAP_VH
`define PTC_MAP_VH

// Sizes
`define PTC_NSTG       4
`define PTC_SRC_W      5

// Register byte offsets
`define PTC_OFF_CTRL   8'h00
`define PTC_OFF_SEL    8'h04
`define PTC_OFF_STAT   8'h08
`define PTC_OFF_CMD    8'h0C
`define PTC_OFF_CNT    8'h10
`define PTC_OFF_STG0   8'h20
`define PTC_OFF_STG3   8'h2C

// CTRL fields
`define PTC_CTL_EN     0
`define PTC_CTL_XBP    1
`define PTC_CTL_GTB    2
`define PTC_CTL_TXP    3
`define PTC_CTRL_RST   32'h00000001

// SEL fields (5-bit source indices)
`define PTC_SEL_A      0
`define PTC_SEL_B      8
`define PTC_SEL_T      16
`define PTC_SEL_RST    32'h00000000

// Per-stage config fields
`define PTC_STG_EN     0
`define PTC_STG_XBP    1
`define PTC_STG_TPB    2
`define PTC_STG_TXP    3
`define PTC_STG_REV    4
`define PTC_STG_BRK    5
`define PTC_STG_SRC    8
`define PTC_STG_TSRC   16
`define PTC_STG_RST    32'h00000001

// CMD fields
`define PTC_CMD_CLR    0

`endif

// File: src/ptc_stage.v
// Gating of one protection stage: enable, blocking and trip blocking.
// Pure combinational; the top module registers everything it drives.
`default_nettype none

module ptc_stage (
    // Settings and blocking sources
    input  wire        i_master_run,
    input  wire [31:0] i_cfg,
    input  wire        i_blk_sig,
    input  wire        i_trip_sig,
    input  wire        i_rev_sig,
    // Element decisions: L1, L2, L3, ground
    input  wire [3:0]  i_alarm,
    input  wire [3:0]  i_trip,
    // Gated results
    output wire        o_run,
    output wire [3:0]  o_alarm,
    output wire [3:0]  o_trip,
    output wire [3:0]  o_cmd
);
    wire temp_blk;
    wire rev_blk;
    wire cmd_blk;

    // Temporary block needs permit and a live source
    assign temp_blk = i_cfg[`PTC_STG_XBP] & i_blk_sig;
    // Reverse interlock, only for current stages that enable it
    assign rev_blk = i_cfg[`PTC_STG_REV] & i_rev_sig;
    // Stage runs only under master run and its own enable
    assign o_run = i_master_run & i_cfg[`PTC_STG_EN] & ~temp_blk & ~rev_blk;

    // Disabled or blocked stage contributes nothing
    assign o_alarm = i_alarm & {4{o_run}};
    assign o_trip  = i_trip & {4{o_run}};

    // Trip command blocked permanently or by its own source
    assign cmd_blk = i_cfg[`PTC_STG_TPB] | (i_cfg[`PTC_STG_TXP] & i_trip_sig);
    // Only breaker-assigned stages reach the breaker
    assign o_cmd = o_trip & {4{~cmd_blk & i_cfg[`PTC_STG_BRK]}};

endmodule // ptc_stage

`default_nettype wire

// File: sim/ptc_elem_model.sv
// Behavioural protection elements: four stages, L1 L2 L3 ground each.
// Assumes the bench sets the wanted pick-ups; decisions follow on the clock.
`default_nettype none
module ptc_elem_model (
    // Clock
    input  wire logic        i_clock,
    // Wanted pick-ups
    input  wire logic [15:0] i_alarm_set,
    input  wire logic [15:0] i_trip_set,
    // Decisions toward the supervisor
    output var  logic [15:0] o_alarm = 16'h0000,
    output var  logic [15:0] o_trip  = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    // Registered, since real elements decide on the system clock
    always @(posedge i_clock) begin
        o_alarm <= i_alarm_set;
        o_trip  <= i_trip_set;
    end
endmodule // ptc_elem_model
`default_nettype wire

// File: sim/ptc_monitor.sv
// Checker of the protection supervisor's port behaviour.
// Assumes it is bound to ptc_top and sees only its ports.
`default_nettype none
`include "ptc_map.vh"
module ptc_monitor (
    // Clock, reset and bus
    input wire logic        I_CLOCK,
    input wire logic        I_SRST,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [7:0]  I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic        O_PREADY,
    // Element decisions
    input wire logic [15:0] I_STG_ALARM,
    input wire logic [15:0] I_STG_TRIP,
    // Status and collectives
    input wire logic [3:0]  O_STG_RUN,
    input wire logic        O_PROT_ACTIVE,
    input wire logic        O_EXT_BLOCK,
    input wire logic        O_TRIP_BLOCKED,
    input wire logic        O_PHASE1_GENERAL_ALARM,
    input wire logic        O_PHASE1_GENERAL_TRIP,
    input wire logic        O_GROUND_GENERAL_TRIP,
    input wire logic        O_GENERAL_ALARM,
    input wire logic        O_GENERAL_TRIP,
    input wire logic        O_BREAKER_TRIP,
    input wire logic        O_CNT_RESET
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge I_CLOCK);
    endclocking
    default disable iff (I_SRST);
    // Completing write of the clear bit
    wire cmd_clr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == `PTC_OFF_CMD && I_PWDATA[0];
    // Slave answers after exactly one wait state
    sequence s_one_wait;
        !O_PREADY ##1 O_PREADY;
    endsequence
    a_apb_one_wait: assert property (I_PSEL && I_PENABLE && !$past(I_PENABLE) |-> s_one_wait)
        else $error("bus answer not after one wait state");
    // Collectives need a cause one edge earlier
    a_phase1_alarm_or: assert property (O_PHASE1_GENERAL_ALARM |-> ($past(I_STG_ALARM) & 16'h1111) != 16'h0000)
        else $error("phase 1 alarm without any phase 1 element alarm");
    a_phase1_trip_or: assert property (O_PHASE1_GENERAL_TRIP |-> ($past(I_STG_TRIP) & 16'h1111) != 16'h0000)
        else $error("phase 1 trip without any phase 1 element trip");
    a_ground_trip_or: assert property (O_GROUND_GENERAL_TRIP |-> ($past(I_STG_TRIP) & 16'h8888) != 16'h0000)
        else $error("ground trip without any ground element trip");
    a_general_alarm_or: assert property (O_GENERAL_ALARM |-> $past(I_STG_ALARM) != 16'h0000)
        else $error("general alarm without any element alarm");
    // Breaker only sees a subset of the decisions
    a_breaker_subset: assert property (O_BREAKER_TRIP |-> O_GENERAL_TRIP)
        else $error("breaker trip without a general trip");
    a_trip_block_holds: assert property (O_TRIP_BLOCKED && $past(O_TRIP_BLOCKED) |-> !O_BREAKER_TRIP)
        else $error("breaker trip while trips are blocked");
    // One cycle of slack, in case run lags the block flag
    a_ext_block_stops: assert property (O_EXT_BLOCK && $past(O_EXT_BLOCK) |-> O_STG_RUN == 4'h0 && !O_PROT_ACTIVE)
        else $error("stages running under a global block");
    a_clear_cause: assert property ($rose(O_CNT_RESET) |-> $past(cmd_clr) || $past(cmd_clr, 2))
        else $error("counter clear pulse without a clear command");
    a_clear_single: assert property (O_CNT_RESET |=> !O_CNT_RESET)
        else $error("counter clear pulse longer than one cycle");
endmodule // ptc_monitor
bind ptc_top ptc_monitor u_ptc_monitor (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
    .I_STG_ALARM(I_STG_ALARM), .I_STG_TRIP(I_STG_TRIP), .O_STG_RUN(O_STG_RUN), .O_PROT_ACTIVE(O_PROT_ACTIVE),
    .O_EXT_BLOCK(O_EXT_BLOCK), .O_TRIP_BLOCKED(O_TRIP_BLOCKED), .O_PHASE1_GENERAL_ALARM(O_PHASE1_GENERAL_ALARM),
    .O_PHASE1_GENERAL_TRIP(O_PHASE1_GENERAL_TRIP), .O_GROUND_GENERAL_TRIP(O_GROUND_GENERAL_TRIP),
    .O_GENERAL_ALARM(O_GENERAL_ALARM), .O_GENERAL_TRIP(O_GENERAL_TRIP), .O_BREAKER_TRIP(O_BREAKER_TRIP),
    .O_CNT_RESET(O_CNT_RESET));
`default_nettype wire

// File: sim/protection_block_and_trip_collector_tb.sv
// Self-checking bench of the protection supervisor.
// Assumes ptc_top, the element model and the bound checker.
`default_nettype none
`include "ptc_map.vh"
module protection_block_and_trip_collector_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [15:0] a; logic [15:0] t; logic [10:0] e;} row_t;
    // Driven here
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0]  din = 8'h00;
    logic        rev = 1'b0;
    logic [15:0] a_set = 16'h0000;
    logic [15:0] t_set = 16'h0000;
    // Observed
    wire  [15:0] alarm, trip;
    wire  [31:0] prdata;
    wire  [3:0]  run;
    wire  [4:0]  al, tr;
    wire         pready, pslverr, act, xblk, tblk, brk, crst;
    logic [31:0] rd;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          i, n;
    // Pick-ups, then alarms L1 L2 L3 G any, trips likewise, breaker
    row_t        rows [6] = '{'{16'h0001, 16'h0000, 11'b10001_00000_0},
        '{16'h0020, 16'h0800, 11'b01001_00011_1}, '{16'h4000, 16'h0001, 11'b00101_10001_1},
        '{16'h8000, 16'h0040, 11'b00011_00101_1}, '{16'h0200, 16'h2000, 11'b01001_01001_1},
        '{16'h0000, 16'h0000, 11'b00000_00000_0}};

    ptc_elem_model u_ptc_elem_model (.i_clock(clk), .i_alarm_set(a_set), .i_trip_set(t_set),
        .o_alarm(alarm), .o_trip(trip));
    ptc_top u_ptc_top (.I_CLOCK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_DIN(din), .I_REV_ILOCK(rev), .I_STG_ALARM(alarm), .I_STG_TRIP(trip), .O_STG_RUN(run),
        .O_PROT_ACTIVE(act), .O_EXT_BLOCK(xblk), .O_TRIP_BLOCKED(tblk), .O_PHASE1_GENERAL_ALARM(al[4]),
        .O_PHASE2_GENERAL_ALARM(al[3]), .O_PHASE3_GENERAL_ALARM(al[2]), .O_GROUND_GENERAL_ALARM(al[1]),
        .O_GENERAL_ALARM(al[0]), .O_PHASE1_GENERAL_TRIP(tr[4]), .O_PHASE2_GENERAL_TRIP(tr[3]),
        .O_PHASE3_GENERAL_TRIP(tr[2]), .O_GROUND_GENERAL_TRIP(tr[1]), .O_GENERAL_TRIP(tr[0]),
        .O_BREAKER_TRIP(brk), .O_CNT_RESET(crst));

    // 40 MHz
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    // APB transfer; pready taken at the rising edge, released right after it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            $display("MISMATCH t=%0t no bus answer", $time);
            mismatches++;
            print_verdict();
        end else begin
            rd = pslverr ? 32'hFFFFFFFF : prdata;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(rd, e);
    endtask

    // Worst path: two sync flops, list copy, run, collective
    task automatic settle(input string s);
        repeat (5) @(posedge clk);
        $display("step %s done", s);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rdc(`PTC_OFF_CTRL, `PTC_CTRL_RST);
        rdc(`PTC_OFF_SEL, `PTC_SEL_RST);
        rdc(`PTC_OFF_STG3, `PTC_STG_RST);
        rdc(`PTC_OFF_STAT, 32'h0000008F);
        rdc(8'h40, 32'hFFFFFFFF);
        chk(act, 1'b1);
        for (i = 0; i < 4; i++)
            apb(1'b1, 8'(`PTC_OFF_STG0 + 4 * i), 32'h00000021);
        // Ordinary collective cases
        for (i = 0; i < 6; i++) begin
            a_set <= rows[i].a;
            t_set <= rows[i].t;
            settle("row");
            chk({al, tr, brk}, rows[i].e);
        end
        // Unassigned stage and stage trip block keep the breaker quiet
        apb(1'b1, `PTC_OFF_STG0 + 8'h04, 32'h00000001);
        apb(1'b1, `PTC_OFF_STG0, 32'h00000025);
        t_set <= 16'h0011;
        settle("breaker");
        chk({tr[4], brk}, 2'b10);
        apb(1'b1, `PTC_OFF_STG0, 32'h00000021);
        apb(1'b1, `PTC_OFF_STG0 + 8'h04, 32'h00000020);
        a_set <= 16'h00F0;
        t_set <= 16'h0010;
        settle("stage off");
        chk({run, al[0], tr[0]}, 6'b1101_00);
        apb(1'b1, `PTC_OFF_STG0 + 8'h04, 32'h00000021);
        apb(1'b1, `PTC_OFF_CTRL, 32'h00000000);
        settle("master off");
        chk({act, run, al[0], tr[0]}, 7'b0);
        // Global block: permit off, then each source
        apb(1'b1, `PTC_OFF_CTRL, 32'h00000001);
        apb(1'b1, `PTC_OFF_SEL, 32'h00000201);
        din <= 8'h01;
        settle("no permit");
        chk(xblk, 1'b0);
        apb(1'b1, `PTC_OFF_CTRL, 32'h00000003);
        settle("source a");
        chk({xblk, act, run, al[0]}, 7'b10_0000_0);
        din <= 8'h02;
        settle("source b");
        chk(xblk, 1'b1);
        din <= 8'h00;
        settle("released");
        chk({xblk, act, run, al[0]}, 7'b01_1111_1);
        apb(1'b1, `PTC_OFF_CTRL, 32'h00000001);
        // Stage 2 blocked by stage 0 trips, an internal signal
        apb(1'b1, `PTC_OFF_STG0 + 8'h08, 32'h00000D23);
        t_set <= 16'h0001;
        settle("internal");
        chk(run, 4'b1011);
        t_set <= 16'h0000;
        settle("internal off");
        chk(run, 4'b1111);
        apb(1'b1, `PTC_OFF_STG3, 32'h00000031);
        rev <= 1'b1;
        settle("interlock");
        chk(run, 4'b0111);
        rev <= 1'b0;
        // Stage trip blocked by input 2
        apb(1'b1, `PTC_OFF_STG0, 32'h00020029);
        din <= 8'h02;
        t_set <= 16'h0001;
        settle("stage trip block");
        chk({tr[0], brk}, 2'b10);
        din <= 8'h00;
        settle("stage trip free");
        chk(brk, 1'b1);
        apb(1'b1, `PTC_OFF_CTRL, 32'h00000005);
        settle("global perm");
        chk({tblk, tr[0], brk}, 3'b110);
        apb(1'b1, `PTC_OFF_CTRL, 32'h00000009);
        apb(1'b1, `PTC_OFF_SEL, 32'h00010000);
        din <= 8'h01;
        settle("global ext");
        chk({tblk, tr[0], brk}, 3'b110);
        din <= 8'h00;
        settle("global ext off");
        chk({tblk, brk}, 2'b01);
        // Counter clear
        t_set <= 16'h0000;
        settle("quiet");
        apb(1'b0, `PTC_OFF_CNT, 32'h00000000);
        chk(rd != 32'h00000000, 1'b1);
        apb(1'b1, `PTC_OFF_CMD, 32'h00000001);
        i = 0;
        repeat (4) begin
            @(posedge clk);
            i += crst;
        end
        chk(i, 1);
        rdc(`PTC_OFF_CNT, 32'h00000000);
        rdc(`PTC_OFF_CMD, 32'h00000000);
        print_verdict();
    end
endmodule // protection_block_and_trip_collector_tb
`default_nettype wire
